// *** wit_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Processor model driving the timer's internal bus
module wit_cpu_model
    import wit_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Bus towards the timer
    output var wit_bus_req_t bus_o,
    input wire logic [7:0] rdata_i
);
    // Idle bus at time zero
    initial begin
        bus_o = '0;
    end

    // One write, held until the taking edge, then released
    task automatic write(input logic [15:0] addr, input logic [15:0] data, input logic word);
        @(posedge clk_i);
        bus_o.wr <= 1'b1;
        bus_o.word <= word;
        bus_o.addr <= addr;
        bus_o.wdata <= data;
        @(posedge clk_i);
        bus_o.wr <= 1'b0;
        bus_o.addr <= ~addr; // Released lines show junk
        bus_o.wdata <= ~data;
    endtask

    // One read, data sampled once the answer stands
    task automatic read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        bus_o.rd <= 1'b1;
        bus_o.word <= 1'b0;
        bus_o.addr <= addr;
        @(posedge clk_i);
        bus_o.rd <= 1'b0;
        bus_o.addr <= ~addr;
        @(posedge clk_i);
        #1;
        data = rdata_i;
    endtask
endmodule // wit_cpu_model

`default_nettype wire

// *** wit_pkg.sv ***
`default_nettype none

// ============================================================
// Shared constants and types of the watchdog / interval timer
package wit_pkg;

    // ============================================================
    // Register addresses (lower 16 bits of the bus address)
    localparam logic [15:0] WIT_ADDR_CNT_CTL_WR = 16'hFFBC; // Shared counter / control write
    localparam logic [15:0] WIT_ADDR_CTL_RD = 16'hFFBC; // timer_control_status read
    localparam logic [15:0] WIT_ADDR_CNT_RD = 16'hFFBD; // timer_count read
    localparam logic [15:0] WIT_ADDR_RST_WR = 16'hFFBE; // reset_control_status write
    localparam logic [15:0] WIT_ADDR_RST_RD = 16'hFFBF; // reset_control_status read

    // ============================================================
    // Password upper bytes
    localparam logic [7:0] WIT_KEY_COUNT = 8'h5A; // Load timer_count / reset bits
    localparam logic [7:0] WIT_KEY_CTRL = 8'hA5; // Load control / clear watchdog flag
    localparam logic [7:0] WIT_CLR_DATA = 8'h00; // Low byte of a flag clear

    // ============================================================
    // Reset values
    localparam logic [7:0] WIT_CNT_RESET = 8'h00; // timer_count
    localparam logic [7:0] WIT_CTL_RESET = 8'h18; // timer_control_status
    localparam logic [7:0] WIT_RST_RESET = 8'h1F; // reset_control_status

    // ============================================================
    // Field positions
    localparam int WIT_CTL_OVF_BIT = 7; // interval_overflow_flag
    localparam int WIT_CTL_MODE_BIT = 6; // watchdog_or_interval_select
    localparam int WIT_CTL_RUN_BIT = 5; // timer_run_enable
    localparam int WIT_CTL_CKS_LSB = 0; // count_clock_select low bit
    localparam int WIT_CKS_W = 3; // count_clock_select width
    localparam int WIT_RST_WATCHDOG_OVERFLOW_FLAG_BIT = 7; // watchdog_overflow_flag
    localparam int WIT_RST_ENA_BIT = 6; // reset_on_overflow_enable
    localparam int WIT_RST_SEL_BIT = 5; // reset_type_select
    localparam logic [7:0] WIT_CTL_RSV_ONES = 8'h18; // Reserved bits read 1
    localparam logic [7:0] WIT_RST_RSV_ONES = 8'h1F; // Reserved bits read 1

    // ============================================================
    // Timing in states (one state is one clock)
    localparam int WIT_OUT_STATES_RST = 132; // Overflow output low, reset on
    localparam int WIT_OUT_STATES_NORST = 130; // Overflow output low, reset off
    localparam int WIT_CHIP_RST_STATES = 518; // Internal chip reset length
    localparam int WIT_PRESC_W = 17; // Prescaler width, up to divide by 131072

    // ============================================================
    // Internal bus request
    typedef struct packed {
        logic wr; // Write strobe, one cycle
        logic rd; // Read strobe, one cycle
        logic word; // 1 for a 16-bit transfer
        logic [15:0] addr; // Lower 16 bits of address
        logic [15:0] wdata; // Write data, upper byte is the key
    } wit_bus_req_t;

    // Overflow output sequencer states
    typedef enum logic [1:0] {
        WIT_ST_RUN = 2'b01,
        WIT_ST_ALARM = 2'b10
    } wit_state_t;

endpackage

`default_nettype wire

// *** wit_watchdog_interval_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reset-control loads 1F only on external reset
// - Watchdog flag set on FF to 00, watchdog mode
// - Watchdog flag clears by read-one then write-zero
// - Reset enable bit raises chip reset on overflow
// - Reset select: 0 power-on, 1 manual reset
// - Reset-control low five bits read as one
// - Only word writes reach the three registers
// - Key 5A loads counter, A5 loads control
// - A5 00 to FFBE clears watchdog flag only
// - Key 5A copies reset enable and select bits
// - Reads at FFBC, FFBD and FFBF
// - Overflow output low 132 or 130 states
// - Chip reset held 518 states with output
// - External reset wins and clears watchdog flag
// - Interval mode overflow raises interrupt request
// - Interval flag and request rise together
// - Watchdog flag rises as output falls
// - Counter write beats a coincident increment
// - Run enable low zeroes counter each cycle without a counter write
// - Clock select picks one of eight prescales
// - Writes and flag reads ignored while output low
// - Watchdog overflow, even without reset, clears counter and control
module wit_watchdog_interval_timer
    import wit_pkg::*;
#(
    parameter int OUT_STATES_RST = WIT_OUT_STATES_RST, // Output low length, reset on
    parameter int OUT_STATES_NORST = WIT_OUT_STATES_NORST, // Output low length, reset off
    parameter int CHIP_RST_STATES = WIT_CHIP_RST_STATES // Chip reset length
) (
    // Clock, reset and freeze
    input wire logic clk_i,
    input wire logic resetn_i, // External reset pin, active low
    input wire logic ce_i, // Clock enable, freezes all state when low
    // Internal bus
    input wire wit_bus_req_t bus_i,
    output logic [7:0] bus_rdata_o, // Read data, valid the cycle after rd
    // Watchdog outputs
    output logic overflow_out_n_o, // Active-low overflow output
    output logic chip_reset_o, // Internal chip reset request
    output logic chip_reset_manual_o, // 1 manual reset, 0 power-on reset
    // Interval timer
    output logic interval_timer_irq_o // Interrupt request
);

    // ============================================================
    // Helpers

    // Prescaler mask for each clock-select code
    function automatic logic [WIT_PRESC_W-1:0] div_mask(input logic [WIT_CKS_W-1:0] sel);
        logic [WIT_PRESC_W-1:0] m;
        m = '0;
        case (sel)
            3'h0: m = 17'h00001; // Divide by 2
            3'h1: m = 17'h0003F; // Divide by 64
            3'h2: m = 17'h0007F; // Divide by 128
            3'h3: m = 17'h001FF; // Divide by 512
            3'h4: m = 17'h007FF; // Divide by 2048
            3'h5: m = 17'h01FFF; // Divide by 8192
            3'h6: m = 17'h07FFF; // Divide by 32768
            default: m = 17'h1FFFF; // Divide by 131072
        endcase
        return m;
    endfunction

    // Decode of a keyed word write
    function automatic logic key_hit(input wit_bus_req_t b, input logic [15:0] a,
                                     input logic [7:0] key);
        return b.addr == a && b.wdata[15:8] == key;
    endfunction

    // ============================================================
    // State
    logic [7:0] timer_count_r; // timer_count
    logic ovf_r; // interval_overflow_flag
    logic mode_r; // watchdog_or_interval_select, 1 watchdog
    logic run_r; // timer_run_enable
    logic [WIT_CKS_W-1:0] cks_r; // count_clock_select
    logic watchdog_overflow_flag_r; // watchdog_overflow_flag
    logic reset_on_overflow_enable_r; // reset_on_overflow_enable
    logic reset_type_select_r; // reset_type_select
    logic ovf_arm_r; // Flag seen as 1 by a read
    logic watchdog_overflow_flag_arm_r; // Flag seen as 1 by a read
    logic [WIT_PRESC_W-1:0] presc_r; // Prescaler
    wit_state_t state_r; // Output sequencer
    logic [7:0] out_cnt_r; // Remaining low states minus one
    logic [9:0] rst_cnt_r; // Remaining chip reset states minus one
    logic chip_rst_r; // Chip reset request
    logic rst_manual_r; // Latched reset type
    logic [7:0] rdata_r; // Read data

    // ============================================================
    // Bus decode
    logic alarm; // Overflow output low
    logic wr_ok; // Word write allowed
    logic cnt_wr; // Counter load
    logic ctl_wr; // Control load
    logic rst_bits_wr; // Reset bits load
    logic watchdog_overflow_flag_clr_wr; // Watchdog flag clear write
    logic rd_ok; // Read counts toward flag clearing
    logic tick; // Count pulse
    logic overflow; // Counter rolls FF to 00
    logic wd_ovfl; // Overflow in watchdog mode
    logic iv_ovfl; // Overflow in interval mode

    assign alarm = state_r == WIT_ST_ALARM;
    assign wr_ok = ce_i && bus_i.wr && bus_i.word && !alarm;
    assign cnt_wr = wr_ok && key_hit(bus_i, WIT_ADDR_CNT_CTL_WR, WIT_KEY_COUNT);
    assign ctl_wr = wr_ok && key_hit(bus_i, WIT_ADDR_CNT_CTL_WR, WIT_KEY_CTRL);
    assign rst_bits_wr = wr_ok && key_hit(bus_i, WIT_ADDR_RST_WR, WIT_KEY_COUNT);
    assign watchdog_overflow_flag_clr_wr = wr_ok && key_hit(bus_i, WIT_ADDR_RST_WR, WIT_KEY_CTRL)
        && bus_i.wdata[7:0] == WIT_CLR_DATA;
    assign rd_ok = ce_i && bus_i.rd && !alarm;

    // ============================================================
    // Count path
    assign tick = run_r && ((presc_r & div_mask(cks_r)) == div_mask(cks_r));
    // A write in the same cycle discards the increment
    assign overflow = ce_i && tick && !cnt_wr && timer_count_r == 8'hFF;
    assign wd_ovfl = overflow && mode_r;
    assign iv_ovfl = overflow && !mode_r;

    // Prescaler runs only while the timer runs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_r <= '0;
        end else if (ce_i) begin
            if (!run_r || wd_ovfl) begin
                presc_r <= '0;
            end else begin
                presc_r <= presc_r + 17'h00001;
            end
        end
    end

    // Counter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_count_r <= WIT_CNT_RESET;
        end else if (ce_i) begin
            if (wd_ovfl) begin
                timer_count_r <= WIT_CNT_RESET;
            end else if (cnt_wr) begin
                timer_count_r <= bus_i.wdata[7:0];
            end else if (!run_r) begin
                timer_count_r <= WIT_CNT_RESET;
            end else if (tick) begin
                timer_count_r <= timer_count_r + 8'h01;
            end
        end
    end

    // ============================================================
    // Control register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_r <= WIT_CTL_RESET[WIT_CTL_MODE_BIT];
            run_r <= WIT_CTL_RESET[WIT_CTL_RUN_BIT];
            cks_r <= WIT_CTL_RESET[WIT_CTL_CKS_LSB +: WIT_CKS_W];
        end else if (ce_i) begin
            if (wd_ovfl) begin
                // Watchdog overflow returns control to its reset value
                mode_r <= WIT_CTL_RESET[WIT_CTL_MODE_BIT];
                run_r <= WIT_CTL_RESET[WIT_CTL_RUN_BIT];
                cks_r <= WIT_CTL_RESET[WIT_CTL_CKS_LSB +: WIT_CKS_W];
            end else if (ctl_wr) begin
                mode_r <= bus_i.wdata[WIT_CTL_MODE_BIT];
                run_r <= bus_i.wdata[WIT_CTL_RUN_BIT];
                cks_r <= bus_i.wdata[WIT_CTL_CKS_LSB +: WIT_CKS_W];
            end
        end
    end

    // Interval flag, set wins over clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovf_r <= 1'b0;
            ovf_arm_r <= 1'b0;
        end else if (ce_i) begin
            if (iv_ovfl) begin
                ovf_r <= 1'b1;
            end else if (wd_ovfl) begin
                ovf_r <= 1'b0;
                ovf_arm_r <= 1'b0;
            end else if (ctl_wr && ovf_arm_r && !bus_i.wdata[WIT_CTL_OVF_BIT]) begin
                ovf_r <= 1'b0;
                ovf_arm_r <= 1'b0;
            end else if (rd_ok && bus_i.addr == WIT_ADDR_CTL_RD && ovf_r) begin
                ovf_arm_r <= 1'b1;
            end
        end
    end

    // ============================================================
    // Reset-control register, kept across the internal reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // External reset wins and clears the flag
            watchdog_overflow_flag_r <= WIT_RST_RESET[WIT_RST_WATCHDOG_OVERFLOW_FLAG_BIT];
            reset_on_overflow_enable_r <= WIT_RST_RESET[WIT_RST_ENA_BIT];
            reset_type_select_r <= WIT_RST_RESET[WIT_RST_SEL_BIT];
            watchdog_overflow_flag_arm_r <= 1'b0;
        end else if (ce_i) begin
            if (rst_bits_wr) begin
                reset_on_overflow_enable_r <= bus_i.wdata[WIT_RST_ENA_BIT];
                reset_type_select_r <= bus_i.wdata[WIT_RST_SEL_BIT];
            end
            if (wd_ovfl) begin
                watchdog_overflow_flag_r <= 1'b1;
            end else if (watchdog_overflow_flag_clr_wr && watchdog_overflow_flag_arm_r) begin
                watchdog_overflow_flag_r <= 1'b0;
                watchdog_overflow_flag_arm_r <= 1'b0;
            end else if (rd_ok && watchdog_overflow_flag_r
                    && (bus_i.addr == WIT_ADDR_CTL_RD || bus_i.addr == WIT_ADDR_RST_RD)) begin
                watchdog_overflow_flag_arm_r <= 1'b1;
            end
        end
    end

    // ============================================================
    // Overflow output sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= WIT_ST_RUN;
            out_cnt_r <= 8'h00;
        end else if (ce_i) begin
            case (state_r)
                WIT_ST_RUN: begin
                    if (wd_ovfl) begin
                        state_r <= WIT_ST_ALARM;
                        // Length depends on reset enable
                        out_cnt_r <= reset_on_overflow_enable_r ? 8'(OUT_STATES_RST - 1)
                                            : 8'(OUT_STATES_NORST - 1);
                    end
                end
                WIT_ST_ALARM: begin
                    if (out_cnt_r == 8'h00) begin
                        state_r <= WIT_ST_RUN;
                    end else begin
                        out_cnt_r <= out_cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= WIT_ST_RUN;
                end
            endcase
        end
    end

    // Internal chip reset request
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            chip_rst_r <= 1'b0;
            rst_manual_r <= 1'b0;
            rst_cnt_r <= 10'h000;
        end else if (ce_i) begin
            if (wd_ovfl && reset_on_overflow_enable_r) begin
                chip_rst_r <= 1'b1;
                rst_manual_r <= reset_type_select_r;
                rst_cnt_r <= 10'(CHIP_RST_STATES - 1);
            end else if (chip_rst_r) begin
                if (rst_cnt_r == 10'h000) begin
                    chip_rst_r <= 1'b0;
                end else begin
                    rst_cnt_r <= rst_cnt_r - 10'h001;
                end
            end
        end
    end

    // ============================================================
    // Read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i && bus_i.rd) begin
            case (bus_i.addr)
                WIT_ADDR_CTL_RD: rdata_r <= {ovf_r, mode_r, run_r, 2'b00, cks_r}
                    | WIT_CTL_RSV_ONES;
                WIT_ADDR_CNT_RD: rdata_r <= timer_count_r;
                WIT_ADDR_RST_RD: rdata_r <= {watchdog_overflow_flag_r, reset_on_overflow_enable_r, reset_type_select_r, 5'h00}
                    | WIT_RST_RSV_ONES;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign bus_rdata_o = rdata_r;
    assign overflow_out_n_o = !alarm;
    assign chip_reset_o = chip_rst_r;
    assign chip_reset_manual_o = rst_manual_r;
    assign interval_timer_irq_o = ovf_r;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence wd_event_s;
        wd_ovfl && reset_on_overflow_enable_r;
    endsequence
    sequence out_low_s;
        !overflow_out_n_o && chip_reset_o;
    endsequence

    out_len_rst_a: assert property (
        (wd_event_s and ce_i) ##1 (ce_i && overflow_out_n_o == 1'b0) [*8]
        |-> out_cnt_r == 8'(OUT_STATES_RST - 8))
        else $error("overflow output length wrong with reset enabled");
    out_start_a: assert property (wd_ovfl |=> watchdog_overflow_flag_r && !overflow_out_n_o)
        else $error("flag and output did not move together");
    chip_rst_a: assert property (wd_event_s |=> out_low_s)
        else $error("chip reset did not start with output");
    no_chip_rst_a: assert property (wd_ovfl && !reset_on_overflow_enable_r |=> !chip_reset_o)
        else $error("chip reset without enable");
    rst_type_a: assert property (wd_event_s |=> chip_reset_manual_o == $past(reset_type_select_r))
        else $error("wrong reset type");
    iv_flag_a: assert property (iv_ovfl |=> interval_timer_irq_o && !$rose(watchdog_overflow_flag_r))
        else $error("interval overflow misflagged");
    // The request may only rise one cycle after an interval overflow
    iv_irq_a: assert property ($rose(interval_timer_irq_o) |-> $past(iv_ovfl))
        else $error("request rose without interval overflow");
    hold_zero_a: assert property (ce_i && !run_r && !cnt_wr && !wd_ovfl |=> timer_count_r == 8'h00)
        else $error("counter not held at zero");
    write_win_a: assert property (cnt_wr |=> timer_count_r == $past(bus_i.wdata[7:0]))
        else $error("increment beat counter write");
    wr_block_a: assert property (alarm && bus_i.wr |=> $stable(reset_on_overflow_enable_r) && $stable(timer_count_r))
        else $error("write accepted while output low");
    rst_rsv_a: assert property ($past(bus_i.rd && ce_i && bus_i.addr == WIT_ADDR_RST_RD)
        |-> bus_rdata_o[4:0] == 5'h1F)
        else $error("reserved bits not one");
    clr_a: assert property (ce_i && watchdog_overflow_flag_r && !watchdog_overflow_flag_arm_r && !wd_ovfl |=> watchdog_overflow_flag_r)
        else $error("flag cleared without prior read");

endmodule // wit_watchdog_interval_timer

`default_nettype wire

// *** wit_watchdog_interval_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Self-checking bench of the watchdog / interval timer
module wit_watchdog_interval_timer_tb
    import wit_pkg::*;
;
    // Clock, reset and freeze
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    // Bus and outputs
    wit_bus_req_t bus;
    logic [7:0] rdata;
    logic ovf_n, chip_rst, chip_rst_man, irq;
    // Bookkeeping
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int low_cnt = 0, low_len = 0, rst_cnt = 0, rst_len = 0, n;
    logic [7:0] rd;
    int divs[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};

    // ============================================================
    // Design and processor model
    wit_watchdog_interval_timer u_wit_watchdog_interval_timer (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .bus_i(bus), .bus_rdata_o(rdata),
        .overflow_out_n_o(ovf_n), .chip_reset_o(chip_rst), .chip_reset_manual_o(chip_rst_man),
        .interval_timer_irq_o(irq));
    wit_cpu_model u_wit_cpu_model (.clk_i(clk_i), .bus_o(bus), .rdata_i(rdata));

    // Clock at 50 ns
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Timeout ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            print_verdict();
        end
    end

    // Lengths of the low output and of the chip reset
    always @(posedge clk_i) begin
        if (ovf_n === 1'b0) begin
            low_cnt++;
        end else if (low_cnt != 0) begin
            low_len = low_cnt;
            low_cnt = 0;
        end
        if (chip_rst === 1'b1) begin
            rst_cnt++;
        end else if (rst_cnt != 0) begin
            rst_len = rst_cnt;
            rst_cnt = 0;
        end
    end

    // ============================================================
    // Compare and access tasks
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_len(input string name, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        u_wit_cpu_model.write(addr, data, 1'b1);
    endtask

    task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string name);
        u_wit_cpu_model.read(addr, rd);
        check_byte(name, exp, rd);
    endtask

    // Bounded wait for the overflow output to fall
    task automatic wait_fall();
        n = 0;
        while (ovf_n !== 1'b0 && n < 1000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_bit("overflow output", 1'b0, ovf_n);
    endtask

    // One watchdog overflow with given reset bits
    task automatic wd_run(input logic reset_on_overflow_enable, input logic reset_type_select);
        logic [7:0] rs;
        rs = {1'b1, reset_on_overflow_enable, reset_type_select, 5'h1F};
        // Forget lengths left over from an earlier run
        low_len = 0;
        rst_len = 0;
        wr(16'hFFBE, {8'h5A, 1'b0, reset_on_overflow_enable, reset_type_select, 5'h00});
        wr(16'hFFBC, 16'hA560);
        wr(16'hFFBC, 16'h5AF0);
        wait_fall();
        check_bit("chip reset start", reset_on_overflow_enable, chip_rst);
        if (reset_on_overflow_enable) begin
            check_bit("reset type", reset_type_select, chip_rst_man);
        end
        wr(16'hFFBC, 16'h5A33);
        rd_chk(16'hFFBF, rs, "flag while low");
        wr(16'hFFBE, 16'hA500);
        repeat (600) @(posedge clk_i);
        check_len("output low", reset_on_overflow_enable ? 132 : 130, low_len);
        if (reset_on_overflow_enable) begin
            check_len("chip reset", 518, rst_len);
        end else begin
            check_len("no chip reset", 0, rst_len);
        end
        rd_chk(16'hFFBD, 8'h00, "count after overflow");
        rd_chk(16'hFFBC, 8'h18, "control after overflow");
        rd_chk(16'hFFBF, rs, "flag kept");
        wr(16'hFFBE, 16'hA580);
        rd_chk(16'hFFBF, rs, "flag after write one");
        wr(16'hFFBE, 16'hA500);
        rd_chk(16'hFFBF, rs & 8'h7F, "flag cleared");
    endtask

    // Closing report
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd_chk(16'hFFBC, 8'h18, "control reset");
        rd_chk(16'hFFBD, 8'h00, "count reset");
        rd_chk(16'hFFBF, 8'h1F, "reset ctl reset");
        rd_chk(16'hFFC0, 8'h00, "unmapped read");
        u_wit_cpu_model.write(16'hFFBE, 16'h5A60, 1'b0);
        u_wit_cpu_model.write(16'hFFBC, 16'hA520, 1'b0);
        rd_chk(16'hFFBF, 8'h1F, "byte write reset ctl");
        rd_chk(16'hFFBC, 8'h18, "byte write control");
        wr(16'hFFBC, 16'h5A55);
        rd_chk(16'hFFBD, 8'h00, "count held");
        // Clock enable low freezes counter and prescaler
        wr(16'hFFBC, 16'hA520);
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce_i <= 1'b1;
        rd_chk(16'hFFBD, 8'h01, "count frozen");
        wr(16'hFFBC, 16'hA500);
        // Every clock select, counting for selects 1 to 5
        for (int k = 0; k < 8; k++) begin
            wr(16'hFFBC, {8'hA5, 5'b00000, k[2:0]});
            rd_chk(16'hFFBC, 8'h18 | 8'(k), "clock select");
            if (k >= 1 && k <= 5) begin
                wr(16'hFFBC, {8'hA5, 5'b00100, k[2:0]});
                repeat (divs[k] * 3 + divs[k] / 2) @(posedge clk_i);
                rd_chk(16'hFFBD, 8'h03, "prescaled count");
                wr(16'hFFBC, {8'hA5, 5'b00000, k[2:0]});
                rd_chk(16'hFFBD, 8'h00, "count cleared");
            end
        end
        // Interval mode overflow
        wr(16'hFFBC, 16'hA520);
        wr(16'hFFBC, 16'h5AF0);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_bit("interval request", 1'b1, irq);
        rd_chk(16'hFFBC, 8'hB8, "interval flag");
        rd_chk(16'hFFBF, 8'h1F, "no watchdog flag");
        check_bit("output idle", 1'b1, ovf_n);
        wr(16'hFFBC, 16'hA520);
        repeat (2) @(posedge clk_i);
        #1;
        check_bit("request cleared", 1'b0, irq);
        wr(16'hFFBC, 16'hA500);
        // Watchdog overflows
        wd_run(1'b0, 1'b0);
        wd_run(1'b1, 1'b0);
        wd_run(1'b1, 1'b1);
        // External reset on top of an overflow
        wr(16'hFFBE, 16'h5A40);
        wr(16'hFFBC, 16'hA560);
        wr(16'hFFBC, 16'h5AF0);
        wait_fall();
        @(posedge clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd_chk(16'hFFBF, 8'h1F, "external reset wins");
        check_bit("output after reset", 1'b1, ovf_n);
        check_bit("chip reset after reset", 1'b0, chip_rst);
        print_verdict();
    end
endmodule // wit_watchdog_interval_timer_tb

`default_nettype wire
